// ### spc_pkg.sv
// Behaviour
// [R1] All sequencing derives from the single oscillator clock (the 640 kHz reference; here the 50 MHz ref_clk).
// [R2] The host holds reset asserted for at least 12 oscillator periods to initialise the device; the testbench holds it for 10 ref_clk periods.
// [R3] After more than 3 seconds with no chip select, start or reset the device enters standby.
// [R4] In standby a new qualified start, or a reset, takes the device out of standby.
// [R5] Up to 256 messages are selected by an 8-bit message code.
// [R6] The device addresses an external speech ROM of up to 1 Mbit.
// [R7] The message code is captured on the rising edge of start while chip select is asserted.
// [R8] Once start is accepted busy goes low and stays low until the message has finished.
// [R9] Further start strobes are ignored while busy is low.
// [R10] Decoded samples drive a 9-bit unipolar current D/A converter.
// [R11] The host drives role select low for slave operation and high for standalone operation.
// [R12] In standby the busy output floats; otherwise it is an active-low output.
// [R13] On start the device fetches and decodes data for the latched message, then returns to idle.
package spc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned OSC_HZ = 640_000;
  localparam int unsigned IDLE_MS = 3000;
  localparam int unsigned IDLE_CYCLES = (CLK_HZ / 1000) * IDLE_MS;
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int unsigned RESET_OSC_PERIODS = 12;
  localparam int unsigned SAMPLE_DIV_DEFAULT = 8333;
  localparam int CODE_W = 8;
  localparam int ROM_AW = 17;
  localparam int ROM_DW = 8;
  localparam int DAC_W = 9;
  localparam int FIFO_DEPTH = 32;
  localparam logic [ROM_AW-1:0] DIR_ENTRY_BYTES = 17'h0_0002;
  localparam logic [ROM_DW-1:0] END_MARK = 8'h00;
  localparam logic [DAC_W-1:0] DAC_MID = 9'h100;
  localparam logic [DAC_W-1:0] DAC_MAX = 9'h1FF;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_DIR_HI = 6'b00_0010,
    ST_DIR_LO = 6'b00_0100,
    ST_FETCH = 6'b00_1000,
    ST_DRAIN = 6'b01_0000,
    ST_STANDBY = 6'b10_0000
  } spc_state_t;
endpackage : spc_pkg

// ### spc_fifo.sv
`timescale 1ns/1ps
module spc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic flush,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0] count, next_count;
  logic doWr, doRd;

  always_comb begin
    inReady = (count != (AW+1)'(DEPTH));
    outValid = (count != '0);
    outData = mem[rdPtr];
    doWr = inValid && inReady;
    doRd = outValid && outReady;
    next_wrPtr = doWr ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = doRd ? rdPtr + 1'b1 : rdPtr;
    next_count = count + (AW+1)'(doWr) - (AW+1)'(doRd);
    if (flush) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end

  fifo_bound_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    count <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule : spc_fifo

// ### spc_playback.sv
`timescale 1ns/1ps
module spc_playback
  import spc_pkg::*;
#(
  parameter int unsigned IDLE_LIMIT = IDLE_CYCLES,
  parameter int unsigned SAMPLE_DIV = SAMPLE_DIV_DEFAULT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // host control
  input wire logic chip_select_n,
  input wire logic playback_trigger_n,
  input wire logic [CODE_W-1:0] message_code,
  input wire logic role_select_n,
  // busy, two signals of a tri-state pin
  output logic busy_n_out,
  output logic busy_n_oe_n,
  // speech rom
  output logic [ROM_AW-1:0] romAddr,
  output logic romRead,
  input wire logic [ROM_DW-1:0] romData,
  // d/a converter
  output logic [DAC_W-1:0] voice_current_out,
  output logic dacEnable,
  output logic standby
);
  spc_state_t state, next_state;
  logic trigPrev, next_trigPrev;
  logic [CODE_W-1:0] code, next_code;
  logic [ROM_AW-1:0] addr, next_addr;
  logic rdPend, next_rdPend;
  logic [ROM_AW-1:0] startHi, next_startHi;
  logic [31:0] idleCnt, next_idleCnt;
  logic [15:0] smpCnt, next_smpCnt;
  logic [DAC_W-1:0] dac, next_dac;
  logic busyN, next_busyN;
  logic oeN, next_oeN;
  logic sbFlag, next_sbFlag;
  logic dacOn, next_dacOn;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  logic [ROM_DW-1:0] fifoOutData;
  logic trigRise, qualStart, activity, flush;

  // nibble step applied to the 9-bit level; unipolar, clipped at both ends
  function automatic logic [DAC_W-1:0] step_level(input logic [DAC_W-1:0] lvl,
                                                  input logic [3:0] nib);
    logic [DAC_W:0] sum;
    sum = '0;
    if (nib[3]) begin
      sum = {1'b0, lvl} - {{(DAC_W-2){1'b0}}, nib[2:0]};
      if (sum[DAC_W]) sum = '0;
    end else begin
      sum = {1'b0, lvl} + {{(DAC_W-2){1'b0}}, nib[2:0]};
      if (sum[DAC_W]) sum = {1'b0, DAC_MAX};
    end
    return sum[DAC_W-1:0];
  endfunction : step_level

  spc_fifo #(.WIDTH(ROM_DW), .DEPTH(FIFO_DEPTH)) speechBuf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .flush(flush),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(romData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  always_comb begin
    // inputs are synchronous; start edge is its release (low to high)
    trigRise = playback_trigger_n && !trigPrev; // R7
    qualStart = trigRise && !chip_select_n && role_select_n; // R11
    activity = !chip_select_n || !playback_trigger_n;
    flush = (state == ST_IDLE) || (state == ST_STANDBY);
    fifoInValid = rdPend;
    fifoOutReady = (state inside {ST_FETCH, ST_DRAIN}) && (smpCnt == '0);
    next_trigPrev = playback_trigger_n;
    next_state = state;
    next_code = code;
    next_addr = addr;
    next_rdPend = 1'b0;
    next_startHi = startHi;
    next_idleCnt = activity ? '0 : idleCnt + 1;
    next_smpCnt = (smpCnt == '0) ? 16'(SAMPLE_DIV - 1) : smpCnt - 1'b1;
    next_dac = dac;
    next_busyN = busyN;
    next_oeN = 1'b0; // R12
    next_sbFlag = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_busyN = 1'b1;
        if (qualStart) begin // R9
          next_code = message_code; // R5
          next_addr = ROM_AW'(message_code) * DIR_ENTRY_BYTES; // R6
          next_rdPend = 1'b1;
          next_busyN = 1'b0; // R8
          next_state = ST_DIR_HI;
        end else if (idleCnt >= IDLE_LIMIT) begin // R3
          next_state = ST_STANDBY;
          next_oeN = 1'b1;
          next_sbFlag = 1'b1;
          // silence the converter from the first standby cycle, not one later
          next_dac = '0; // R12
        end
      end
      ST_DIR_HI: begin
        next_startHi = {1'b0, romData, 8'h00};
        next_addr = addr + 1'b1;
        next_rdPend = 1'b1;
        next_state = ST_DIR_LO;
        fifoInValid = 1'b0;
      end
      ST_DIR_LO: begin
        next_addr = startHi | ROM_AW'(romData); // R13
        next_rdPend = 1'b1;
        next_state = ST_FETCH;
        fifoInValid = 1'b0;
        next_dac = DAC_MID;
      end
      ST_FETCH: begin
        if (rdPend && romData == END_MARK) begin
          fifoInValid = 1'b0;
          next_state = ST_DRAIN;
        end else begin
          // back-pressure: hold the read on the same address until the buffer can take the byte
          if (!rdPend || fifoInReady) begin
            next_rdPend = 1'b1;
            if (rdPend) next_addr = addr + 1'b1;
          end else begin
            next_rdPend = rdPend;
            fifoInValid = 1'b0;
          end
        end
      end
      ST_DRAIN: begin
        if (!fifoOutValid) begin
          next_state = ST_IDLE;
          next_busyN = 1'b1; // R8
          next_idleCnt = '0;
        end
      end
      ST_STANDBY: begin
        next_oeN = 1'b1; // R12
        next_sbFlag = 1'b1;
        next_dac = '0;
        next_idleCnt = '0;
        if (qualStart) begin // R4
          next_code = message_code;
          next_addr = ROM_AW'(message_code) * DIR_ENTRY_BYTES;
          next_rdPend = 1'b1;
          next_busyN = 1'b0;
          next_oeN = 1'b0;
          next_sbFlag = 1'b0;
          next_state = ST_DIR_HI;
        end
      end
    endcase
    if (fifoOutReady && fifoOutValid) begin
      next_dac = step_level(dac, fifoOutData[3:0]); // R10
    end
    next_dacOn = !next_sbFlag;
  end

  always_ff @(posedge ref_clk) begin // R1
    if (sys_rst) begin // R2 R4
      state <= ST_IDLE;
      trigPrev <= 1'b1;
      code <= '0;
      addr <= '0;
      rdPend <= 1'b0;
      startHi <= '0;
      idleCnt <= '0;
      smpCnt <= '0;
      dac <= '0;
      busyN <= 1'b1;
      oeN <= 1'b0;
      sbFlag <= 1'b0;
      dacOn <= 1'b1;
    end else begin
      state <= next_state;
      trigPrev <= next_trigPrev;
      code <= next_code;
      addr <= next_addr;
      rdPend <= next_rdPend;
      startHi <= next_startHi;
      idleCnt <= next_idleCnt;
      smpCnt <= next_smpCnt;
      dac <= next_dac;
      busyN <= next_busyN;
      oeN <= next_oeN;
      sbFlag <= next_sbFlag;
      dacOn <= next_dacOn;
    end
  end

  always_comb begin
    busy_n_out = busyN;
    busy_n_oe_n = oeN;
    romAddr = addr;
    romRead = rdPend;
    voice_current_out = dac;
    dacEnable = dacOn;
    standby = sbFlag;
  end

  busy_on_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (qualStart && state == ST_IDLE) |=> !busy_n_out) // R8
    else $error("busy did not fall after accepted start");
  start_ignored_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!busy_n_out && state != ST_DRAIN) |=> $stable(code)) // R9
    else $error("message code changed while busy");
  code_capture_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == ST_IDLE && qualStart) |=> code == $past(message_code)) // R7
    else $error("message code not captured on start");
  standby_float_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    standby |-> busy_n_oe_n && voice_current_out == '0) // R12
    else $error("busy driven or dac live in standby");
  idle_entry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == ST_IDLE && !qualStart && idleCnt >= IDLE_LIMIT) |=> standby) // R3
    else $error("no standby after idle limit");
  wake_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == ST_STANDBY && qualStart) |=> !standby ##0 state == ST_DIR_HI) // R4
    else $error("qualified start did not wake device");
  busy_release_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == ST_DRAIN && !fifoOutValid) |=> busy_n_out ##0 state == ST_IDLE) // R13
    else $error("busy not released at message end");
  dir_addr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == ST_IDLE && qualStart) |=> romAddr == ROM_AW'($past(message_code)) * 2) // R6
    else $error("directory address wrong");
endmodule : spc_playback

// ### spc_rom_model.sv
`timescale 1ns/1ps
module spc_rom_model
  import spc_pkg::*;
#(
  parameter int LONG_CODE = 8'h80,
  parameter int LONG_LEN = 60
) (
  // rom side
  input wire logic ref_clk,
  input wire logic [ROM_AW-1:0] romAddr,
  input wire logic romRead,
  output logic [ROM_DW-1:0] romData
);
  logic [ROM_DW-1:0] mem [0:4095];
  logic [ROM_DW-1:0] lastData = 8'h5A;
  logic [15:0] start;
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    for (int c = 0; c < 256; c++) begin
      // one long message sits past all short ones so it can fill the buffer
      start = (c == LONG_CODE) ? 16'h0A00 : 16'h0200 + 16'(c * 8);
      mem[2 * c] = start[15:8];
      mem[2 * c + 1] = start[7:0];
      // bit 4 set keeps every data byte clear of the end marker
      for (int k = 0; k < ((c == LONG_CODE) ? LONG_LEN : c % 4 + 1); k++) begin
        mem[start + k] = 8'h10 | 8'((c == LONG_CODE) ? k % 8 : c % 16);
      end
    end
  end
  // data valid in the same cycle as the registered address; a released bus
  // shows the inverse of what it last carried
  always @(posedge ref_clk) if (romRead === 1'b1) lastData <= romData;
  assign romData = (romRead === 1'b1) ? mem[romAddr[11:0]] : ~lastData;
endmodule : spc_rom_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import spc_pkg::*;
  logic ref_clk = 0, sys_rst = 1, csN = 1, trigN = 1, roleN = 1;
  logic [CODE_W-1:0] code = 8'h00;
  localparam int LONG_CODE = 8'h80;
  localparam int LONG_LEN = 60;
  logic busyOut, busyOe, romRead, dacEn, stby;
  logic [ROM_AW-1:0] romAddr;
  logic [ROM_DW-1:0] romData;
  logic [DAC_W-1:0] dac;
  int err_total = 0, comparisons = 0, seed = 45239;
  int maxAddr = 0, badAddr = -1, badHits = 0, stalls = 0, prevAddr = -1;
  spc_playback #(.IDLE_LIMIT(200), .SAMPLE_DIV(4)) DUT (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .chip_select_n(csN), .playback_trigger_n(trigN),
    .message_code(code), .role_select_n(roleN), .busy_n_out(busyOut),
    .busy_n_oe_n(busyOe), .romAddr(romAddr), .romRead(romRead), .romData(romData),
    .voice_current_out(dac), .dacEnable(dacEn), .standby(stby));
  spc_rom_model #(.LONG_CODE(LONG_CODE), .LONG_LEN(LONG_LEN)) rom (.ref_clk(ref_clk),
    .romAddr(romAddr), .romRead(romRead), .romData(romData));
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (romRead === 1'b1) begin
      if (int'(romAddr) > maxAddr) maxAddr = int'(romAddr);
      if (int'(romAddr) == badAddr) badHits++;
      // same address read twice in a row: the full buffer held the fetch back
      if (int'(romAddr) == prevAddr) stalls++;
      prevAddr = int'(romAddr);
    end else begin
      prevAddr = -1;
    end
  end
  function automatic int msg_len(input int c);
    return (c == LONG_CODE) ? LONG_LEN : c % 4 + 1;
  endfunction : msg_len
  function automatic int msg_start(input int c);
    return (c == LONG_CODE) ? 32'h0000_0A00 : 512 + 8 * c;
  endfunction : msg_start
  // level after every step of a message, clipped to the converter's range
  function automatic int exp_level(input int c);
    int lvl, nib;
    lvl = int'(DAC_MID);
    for (int k = 0; k < msg_len(c); k++) begin
      nib = (c == LONG_CODE) ? k % 8 : c % 16;
      lvl = (nib < 8) ? lvl + nib : lvl - nib % 8;
      if (lvl < 0) lvl = 0;
      if (lvl > int'(DAC_MAX)) lvl = int'(DAC_MAX);
    end
    return lvl;
  endfunction : exp_level
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic pulse(input logic [7:0] c, input logic cs, input logic role);
    code = c;
    csN = cs;
    roleN = role;
    trigN = 0;
    tick();
    tick();
    trigN = 1;
    tick();
    csN = 1;
  endtask : pulse
  task automatic waitBusy(input logic lvl, input int lim);
    for (int i = 0; i < lim && busyOut !== lvl; i++) tick();
  endtask : waitBusy
  task automatic play(input logic [7:0] c, input bit again);
    maxAddr = 0;
    pulse(c, 0, 1);
    waitBusy(0, 4);
    check("busy low", 0, busyOut);
    check("dir addr", 2 * c, romAddr);
    check("rom read", 1, romRead);
    if (again) begin
      badAddr = 2 * (c ^ 8'h55);
      tick();
      pulse(c ^ 8'h55, 0, 1);
    end
    waitBusy(1, 1000);
    check("busy done", 1, busyOut);
    check("last addr", msg_start(c) + msg_len(c), maxAddr);
    check("dac level", exp_level(c), dac);
    check("ignored starts", 0, badHits);
    badAddr = -1;
  endtask : play
  task automatic idle(input int cyc);
    repeat (cyc) tick();
  endtask : idle
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #(20 * 60000);
    err_total++;
    print_verdict();
  end
  initial begin
    idle(10);
    sys_rst = 0;
    check("rst busy", 1, busyOut);
    check("rst oe", 0, busyOe);
    check("rst standby", 0, stby);
    $display("test reset done");
    play(8'h00, 0);
    play(8'hFF, 1);
    for (int i = 0; i < 6; i++) play(8'($random(seed)), i % 2);
    $display("test playback done");
    pulse(8'h21, 1, 1);
    idle(4);
    check("cs high start", 1, busyOut);
    pulse(8'h22, 0, 0);
    idle(4);
    check("slave start", 1, busyOut);
    $display("test refusals done");
    idle(150);
    check("not yet standby", 0, stby);
    idle(100);
    check("standby", 1, stby);
    check("busy float", 1, busyOe);
    check("dac off", 0, dacEn);
    play(8'h37, 0);
    check("start wakes", 0, stby);
    idle(260);
    sys_rst = 1;
    idle(10);
    sys_rst = 0;
    tick();
    check("reset wakes", 0, stby);
    $display("test standby done");
    stalls = 0;
    play(8'(LONG_CODE), 0);
    check("buffer stall", 1, stalls > 0);
    idle(8);
    check("dac hold", exp_level(LONG_CODE), dac);
    $display("test buffer done");
    print_verdict();
  end
endmodule : testbench
